// [rtl/flash_host_cfg.svh]
// constants for the parallel flash command host
// assumes an asynchronous nor flash on a 20-bit address, 16-bit data bus
`ifndef FLASH_HOST_CFG_SVH
`define FLASH_HOST_CFG_SVH
`define UNLOCK1_WORD   20'h0_0555
`define UNLOCK2_WORD   20'h0_02AA
`define UNLOCK1_BYTE   20'h0_0AAA
`define UNLOCK2_BYTE   20'h0_0555
`define QUERY_WORD     20'h0_0055
`define QUERY_BYTE     20'h0_00AA
`define DAT_AA         8'hAA
`define DAT_55         8'h55
`define CMD_PROGRAM    8'hA0
`define CMD_RESET      8'hF0
`define CMD_IDENT      8'h90
`define CMD_QUERY      8'h98
`define CMD_BYPASS     8'h20
`define CMD_BYP_EXIT2  8'h00
`define CMD_ERASE_SET  8'h80
`define CMD_CHIP_ERASE 8'h10
`define CMD_SECT_ERASE 8'h30
`define CMD_SUSPEND    8'hB0
`define CMD_RESUME     8'h30
`define ID_MAKER_OFS   20'h0_0000
`define ID_DEV_WORD    20'h0_0001
`define ID_DEV_BYTE    20'h0_0002
`define ID_PROT_WORD   20'h0_0002
`define ID_PROT_BYTE   20'h0_0004
`define SECT_LSB       12
`define ERASE_WIN_NS   50000
`define CLK_NS         4
`define SEQ_MAX        6
`endif

// [rtl/flash_host_pkg.sv]
// types shared by the flash command host
// assumes flash_host_cfg.svh holds the numbers
`default_nettype none
package flash_host_pkg;
  typedef enum logic [3:0] {
    OP_READ      = 4'b0000,
    OP_RESET     = 4'b0001,
    OP_IDENT     = 4'b0010,
    OP_QUERY     = 4'b0011,
    OP_PROGRAM   = 4'b0100,
    OP_BYP_ENTER = 4'b0101,
    OP_BYP_PROG  = 4'b0110,
    OP_BYP_EXIT  = 4'b0111,
    OP_CHIP_ERA  = 4'b1000,
    OP_SECT_ERA  = 4'b1001,
    OP_SECT_ADD  = 4'b1010,
    OP_SUSPEND   = 4'b1011,
    OP_RESUME    = 4'b1100
  } op_e;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SETUP = 3'b001,
    ST_LOW   = 3'b010,
    ST_HIGH  = 3'b011,
    ST_GAP   = 3'b100
  } bus_e;
endpackage
`default_nettype wire

// [rtl/flash_seq_rom.sv]
// cycle table: address/data of each bus cycle of a command sequence
// assumes the caller registers op and index on its own clock
`timescale 1ns/100ps
`default_nettype none
`include "flash_host_cfg.svh"
module flash_seq_rom import flash_host_pkg::*; (
  input  wire logic        clock_i,
  input  wire logic        ce_i,
  input  wire op_e         op_i,
  input  wire logic [2:0]  idx_i,
  input  wire logic        byte_mode_i,
  input  wire logic [19:0] user_addr_i,
  input  wire logic [15:0] user_data_i,
  output logic [19:0]      rd_addr_o,
  output logic [15:0]      rd_data_o,
  output logic             rd_is_read_o,
  output logic [2:0]       rd_len_o
);
  op_e         op;
  logic [2:0]  idx;
  logic        byte_mode;
  logic [19:0] user_addr;
  logic [15:0] user_data;
  logic [19:0] u1, u2, a;
  logic [15:0] d;
  logic        r;
  logic [2:0]  n;
  // short local names keep the table readable
  assign op        = op_i;
  assign idx       = idx_i;
  assign byte_mode = byte_mode_i;
  assign user_addr = user_addr_i;
  assign user_data = user_data_i;
  // unlock addresses follow bus width; upper data byte zero as it is ignored
  always_comb begin
    u1 = byte_mode ? `UNLOCK1_BYTE : `UNLOCK1_WORD;
    u2 = byte_mode ? `UNLOCK2_BYTE : `UNLOCK2_WORD;
    a = u1;
    d = {8'h00, `DAT_AA};
    r = 1'b0;
    n = 3'd1;
    if (idx == 3'd1 || idx == 3'd4) begin
      a = u2;
      d = {8'h00, `DAT_55};
    end
    case (op)
      OP_RESET:  begin a = user_addr; d = {8'h00, `CMD_RESET}; end // [RULE4]
      OP_QUERY:  begin a = byte_mode ? `QUERY_BYTE : `QUERY_WORD; d = {8'h00, `CMD_QUERY}; end // [RULE7]
      OP_SUSPEND: begin a = user_addr; d = {8'h00, `CMD_SUSPEND}; end // [RULE11]
      OP_RESUME: begin a = user_addr; d = {8'h00, `CMD_RESUME}; end // [RULE13]
      OP_SECT_ADD: begin a = user_addr; d = {8'h00, `CMD_SECT_ERASE}; end // [RULE18]
      OP_READ:   begin a = user_addr; r = 1'b1; end // plain read, no unlock [RULE17]
      OP_IDENT: begin // [RULE5] [RULE6]
        n = 3'd4;
        if (idx == 3'd2) d = {8'h00, `CMD_IDENT};
        if (idx == 3'd3) begin a = user_addr; r = 1'b1; end // [RULE14]
      end
      OP_PROGRAM: begin // [RULE1]
        n = 3'd4;
        if (idx == 3'd2) d = {8'h00, `CMD_PROGRAM};
        if (idx == 3'd3) begin a = user_addr; d = user_data; end
      end
      OP_BYP_ENTER: begin // [RULE8]
        n = 3'd3;
        if (idx == 3'd2) d = {8'h00, `CMD_BYPASS};
      end
      OP_BYP_PROG: begin // [RULE8]
        n = 3'd2;
        a = user_addr;
        d = (idx == 3'd0) ? {8'h00, `CMD_PROGRAM} : user_data;
      end
      OP_BYP_EXIT: begin // [RULE9]
        n = 3'd2;
        a = user_addr;
        d = (idx == 3'd0) ? {8'h00, `CMD_IDENT} : {8'h00, `CMD_BYP_EXIT2};
      end
      OP_CHIP_ERA, OP_SECT_ERA: begin // [RULE10]
        n = 3'd6;
        if (idx == 3'd2) d = {8'h00, `CMD_ERASE_SET};
        if (idx == 3'd5) begin
          d = {8'h00, (op == OP_CHIP_ERA) ? `CMD_CHIP_ERASE : `CMD_SECT_ERASE};
          if (op == OP_SECT_ERA) a = {user_addr[19:`SECT_LSB], {`SECT_LSB{1'b0}}};
        end
      end
      default: begin a = user_addr; r = 1'b1; end
    endcase
  end
  // registered table output
  always_ff @(posedge clock_i) begin
    if (ce_i) begin
      rd_addr_o    <= a;
      rd_data_o    <= d;
      rd_is_read_o <= r;
      rd_len_o     <= n;
    end
  end
endmodule // flash_seq_rom
`default_nettype wire

// [rtl/flash_host.sv]
// host that issues nor flash command sequences over the async strobe pins
// assumes one 250 MHz clock; flash data pins are a tristate bus resolved by the bench
// What this block does
// (RULE1) program: AA, 55, A0 at unlock addresses then data at target.
// (RULE2) device latches program address at the later falling strobe edge.
// (RULE3) device latches program data at the first rising strobe edge.
// (RULE4) single F0 write anywhere returns flash to array reads.
// (RULE5) identification: three unlocks ending 90, then read maker or device code.
// (RULE6) identification read at sector offset 2/4 gives protection state.
// (RULE7) query entry: 98 written to 55 word or AA byte.
// (RULE8) bypass entry with 20, then two-cycle A0 plus data program.
// (RULE9) bypass exit writes 90 then 00 to any address.
// (RULE10) erases are six writes ending 10 chip or 30 at sector.
// (RULE11) B0 anywhere suspends, valid only during sector erase.
// (RULE12) suspended erase allows reads, programs elsewhere and identification; the host also accepts reset and does not check the program address.
// (RULE13) 30 anywhere resumes, valid only while suspended.
// (RULE14) every command cycle writes except plain reads and identification's last.
// (RULE15) upper data byte ignored on unlock and command cycles.
// (RULE16) upper address bits ignored unless sector or program address.
// (RULE17) plain reads need no unlock or command cycle.
// (RULE18) after sector erase, 50 us window accepts more sector/30 pairs.
// (RULE19) in bypass only bypass program and bypass exit are accepted; the host also accepts plain reads in bypass.
// (RULE20) flash suspends active erase within 20 us.
// (RULE21) mismatched cycle abandons sequence, flash returns to array reads.
// (RULE22) unlock addresses chosen by byte or word bus width.
`timescale 1ns/100ps
`default_nettype none
`include "flash_host_cfg.svh"
module flash_host import flash_host_pkg::*; #(
  parameter int SETUP_CYC = 2,
  parameter int PULSE_CYC = 10,
  parameter int HOLD_CYC  = 2,
  parameter int GAP_CYC   = 5,
  parameter int ERASE_WIN_CYC = `ERASE_WIN_NS / `CLK_NS
) (
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  input  wire logic        req_i,
  input  wire logic [3:0]  op_i,
  input  wire logic [19:0] addr_i,
  input  wire logic [15:0] data_i,
  input  wire logic        byte_mode_i,
  input  wire logic [15:0] dq_i,
  output logic             busy_o,
  output logic             done_o,
  output logic             refused_o,
  output logic [15:0]      rdata_o,
  output logic             bypass_o,
  output logic             suspended_o,
  output logic             window_o,
  output logic [19:0]      addr_o,
  output logic [15:0]      dq_o,
  output logic             dq_oe_o,
  output logic             chip_en_n_o,
  output logic             write_en_n_o,
  output logic             out_en_n_o
);
  logic        rst_m, rst_s;
  logic [15:0] dq_m, dq_s;
  bus_e        st, next_st;
  op_e         op, next_op;
  logic [2:0]  idx, next_idx;
  logic [15:0] cnt, next_cnt;
  logic [31:0] win, next_win;
  logic        byp, next_byp, sus, next_sus, erasing, next_erasing;
  logic        chip, next_chip; // a chip erase cannot be suspended
  logic        busy, next_busy, done, next_done, refd, next_refd;
  logic [15:0] rdata, next_rdata;
  logic [19:0] uaddr, next_uaddr;
  logic [15:0] udata, next_udata;
  logic        bmode, next_bmode;
  logic [19:0] next_addr;
  logic [15:0] next_dq;
  logic        next_oe, next_cen, next_wen, next_oen;
  logic [19:0] t_addr;
  logic [15:0] t_data;
  logic        t_read;
  logic [2:0]  t_len;

  // reset release and pin input synchronisers
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_m <= 1'b0;
      rst_s <= 1'b0;
    end else begin
      rst_m <= 1'b1;
      rst_s <= rst_m;
    end
  end
  always_ff @(posedge clock_i or negedge rst_s) begin
    if (!rst_s) begin
      dq_m <= 16'h0000;
      dq_s <= 16'h0000;
    end else if (ce_i) begin
      dq_m <= dq_i;
      dq_s <= dq_m;
    end
  end

  flash_seq_rom u_rom (
    .clock_i      (clock_i),
    .ce_i         (ce_i),
    .op_i         (op),
    .idx_i        (idx),
    .byte_mode_i  (bmode),
    .user_addr_i  (uaddr),
    .user_data_i  (udata),
    .rd_addr_o    (t_addr),
    .rd_data_o    (t_data),
    .rd_is_read_o (t_read),
    .rd_len_o     (t_len)
  );

  // legality of a new request against the flash mode the host believes in
  function automatic logic legal(input op_e o, input logic b, input logic s,
                                 input logic e, input logic c, input logic w);
    legal = 1'b1;
    if (b) legal = (o == OP_BYP_PROG) || (o == OP_BYP_EXIT) || (o == OP_READ); // [RULE19]
    else if (o == OP_SUSPEND) legal = e && !s && !c;                           // [RULE11]
    else if (o == OP_RESUME) legal = s;                                        // [RULE13]
    else if (o == OP_SECT_ADD) legal = w;                                      // [RULE18]
    else if (s) legal = (o == OP_READ) || (o == OP_PROGRAM) || (o == OP_IDENT) || (o == OP_RESET); // [RULE12]
    else if (e) legal = (o == OP_READ);
    else if (o == OP_BYP_PROG || o == OP_BYP_EXIT) legal = 1'b0;               // [RULE8]
  endfunction

  // strobe sequencer: one bus cycle per idx, read cycles use output enable
  always_comb begin
    next_st = st; next_op = op; next_idx = idx; next_cnt = cnt;
    next_byp = byp; next_sus = sus; next_erasing = erasing; next_chip = chip;
    next_busy = busy; next_done = 1'b0; next_refd = 1'b0; next_rdata = rdata;
    next_uaddr = uaddr; next_udata = udata; next_bmode = bmode;
    next_addr = addr_o; next_dq = dq_o; next_oe = dq_oe_o;
    next_cen = chip_en_n_o; next_wen = write_en_n_o; next_oen = out_en_n_o;
    next_win = (win != 32'd0) ? win - 32'd1 : 32'd0; // window counts down to zero and holds there [RULE18]
    case (st)
      ST_IDLE: begin
        if (req_i) begin
          if (legal(op_e'(op_i), byp, sus, erasing, chip, win != 32'd0)) begin
            next_op = op_e'(op_i); next_idx = 3'd0; next_busy = 1'b1;
            next_uaddr = addr_i; next_udata = data_i;
            next_bmode = byte_mode_i; // [RULE22]
            next_st = ST_SETUP; next_cnt = 16'd0;
          end else begin
            next_refd = 1'b1;
          end
        end
      end
      ST_SETUP: begin // table output valid one clock after idx changes
        next_addr = t_addr; next_dq = t_data; next_oe = !t_read; // [RULE14] [RULE15] [RULE16]
        next_cnt = cnt + 16'd1;
        if (cnt >= 16'(SETUP_CYC)) begin
          next_cen = 1'b0; // chip enable falls with or before the strobe [RULE2]
          next_wen = t_read; next_oen = !t_read;
          next_cnt = 16'd0; next_st = ST_LOW;
        end
      end
      ST_LOW: begin
        next_cnt = cnt + 16'd1;
        if (cnt >= 16'(PULSE_CYC)) begin
          if (t_read) next_rdata = dq_s;
          next_wen = 1'b1; next_oen = 1'b1; // strobe rises before chip enable [RULE3]
          next_cnt = 16'd0; next_st = ST_HIGH;
        end
      end
      ST_HIGH: begin
        next_cnt = cnt + 16'd1;
        if (cnt >= 16'(HOLD_CYC)) begin
          next_cen = 1'b1; next_oe = 1'b0; next_cnt = 16'd0; next_st = ST_GAP;
        end
      end
      ST_GAP: begin
        next_cnt = cnt + 16'd1;
        if (cnt >= 16'(GAP_CYC)) begin
          next_cnt = 16'd0;
          if (idx + 3'd1 < t_len) begin
            next_idx = idx + 3'd1; next_st = ST_SETUP;
          end else begin
            next_st = ST_IDLE; next_busy = 1'b0; next_done = 1'b1;
            case (op)
              OP_RESET:     next_erasing = sus ? erasing : 1'b0; // [RULE4] [RULE21]
              OP_BYP_ENTER: next_byp = 1'b1;                // [RULE8]
              OP_BYP_EXIT:  next_byp = 1'b0;                // [RULE9]
              OP_CHIP_ERA:  begin next_erasing = 1'b1; next_chip = 1'b1; end // [RULE10] [RULE11]
              OP_SECT_ERA, OP_SECT_ADD: begin
                next_erasing = 1'b1;
                next_chip = 1'b0; // [RULE11]
                next_win = 32'(ERASE_WIN_CYC);                // [RULE18]
              end
              OP_SUSPEND: begin next_sus = 1'b1; next_win = 32'd0; end // [RULE11] [RULE20]
              OP_RESUME:  next_sus = 1'b0;                  // [RULE13]
              default: ;
            endcase
          end
        end
      end
      default: next_st = ST_IDLE;
    endcase
  end

  // state registers, frozen while clock enable is low
  always_ff @(posedge clock_i or negedge rst_s) begin
    if (!rst_s) begin
      st <= ST_IDLE; op <= OP_READ; idx <= 3'd0; cnt <= 16'd0; win <= 32'd0;
      byp <= 1'b0; sus <= 1'b0; erasing <= 1'b0; chip <= 1'b0;
      busy <= 1'b0; done <= 1'b0; refd <= 1'b0; rdata <= 16'h0000;
      uaddr <= 20'h0_0000; udata <= 16'h0000; bmode <= 1'b0;
      addr_o <= 20'h0_0000; dq_o <= 16'h0000; dq_oe_o <= 1'b0;
      chip_en_n_o <= 1'b1; write_en_n_o <= 1'b1; out_en_n_o <= 1'b1;
    end else if (ce_i) begin
      st <= next_st; op <= next_op; idx <= next_idx; cnt <= next_cnt; win <= next_win;
      byp <= next_byp; sus <= next_sus; erasing <= next_erasing; chip <= next_chip;
      busy <= next_busy; done <= next_done; refd <= next_refd; rdata <= next_rdata;
      uaddr <= next_uaddr; udata <= next_udata; bmode <= next_bmode;
      addr_o <= next_addr; dq_o <= next_dq; dq_oe_o <= next_oe;
      chip_en_n_o <= next_cen; write_en_n_o <= next_wen; out_en_n_o <= next_oen;
    end
  end

  // status outputs as flip-flops
  always_ff @(posedge clock_i or negedge rst_s) begin
    if (!rst_s) begin
      busy_o <= 1'b0; done_o <= 1'b0; refused_o <= 1'b0; rdata_o <= 16'h0000;
      bypass_o <= 1'b0; suspended_o <= 1'b0; window_o <= 1'b0;
    end else if (ce_i) begin
      busy_o <= next_busy; done_o <= next_done; refused_o <= next_refd; rdata_o <= next_rdata;
      bypass_o <= next_byp; suspended_o <= next_sus; window_o <= (next_win != 32'd0);
    end
  end
endmodule // flash_host
`default_nettype wire

// [dv/flash_host_chk.sv]
// checker on the strobe and status ports of the flash command host
// assumes it is bound to flash_host; one clock, raw async reset
`timescale 1ns/100ps
`default_nettype none
module flash_host_chk (
  input wire logic        clock_i,
  input wire logic        rst_n_i,
  input wire logic        busy_o,
  input wire logic        done_o,
  input wire logic        refused_o,
  input wire logic        suspended_o,
  input wire logic        window_o,
  input wire logic [19:0] addr_o,
  input wire logic [15:0] dq_o,
  input wire logic        dq_oe_o,
  input wire logic        chip_en_n_o,
  input wire logic        write_en_n_o,
  input wire logic        out_en_n_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // write pulse is eleven samples low, then high
  sequence we_low8; !write_en_n_o [*8]; endsequence
  sequence we_end; ##3 !write_en_n_o ##1 write_en_n_o; endsequence
  a_we_pulse_len: assert property ($fell(write_en_n_o) |-> we_low8 ##0 we_end)
    else $error("write pulse length wrong");
  a_we_inside_ce: assert property (!write_en_n_o |-> !chip_en_n_o && dq_oe_o && out_en_n_o)
    else $error("write strobe without chip enable or data");
  a_read_released: assert property (!out_en_n_o |-> !chip_en_n_o && !dq_oe_o)
    else $error("read strobe while host drives data");
  // hazard: flash latches address late and data early, so both must hold
  a_cycle_held: assert property (!chip_en_n_o && !$past(chip_en_n_o) |-> $stable(addr_o)
    && (!dq_oe_o || $stable(dq_o)))
    else $error("address or data moved inside a cycle");
  a_done_single: assert property (done_o |=> !done_o)
    else $error("done longer than one cycle");
  a_refuse_quiet: assert property (refused_o |-> chip_en_n_o && !busy_o && !done_o)
    else $error("refused request touched the bus");
  a_idle_strobes: assert property (!busy_o |-> chip_en_n_o && write_en_n_o && out_en_n_o)
    else $error("strobe active while idle");
  a_suspend_shut: assert property ($rose(suspended_o) |-> !window_o)
    else $error("add window open after suspend");
endmodule // flash_host_chk
bind flash_host flash_host_chk u_chk (.clock_i, .rst_n_i, .busy_o, .done_o, .refused_o, .suspended_o,
  .window_o, .addr_o, .dq_o, .dq_oe_o, .chip_en_n_o, .write_en_n_o, .out_en_n_o);
`default_nettype wire

// [dv/flash_dev_model.sv]
// behavioural parallel nor flash: logs write cycles, answers reads
// assumes word-mode identification reads; no clock of its own
`timescale 1ns/100ps
`default_nettype none
module flash_dev_model #(
  parameter logic [15:0] MAKER  = 16'h00a5, // arbitrary value
  parameter logic [15:0] DEVICE = 16'h5a3c  // arbitrary value
) (
  input  wire logic [19:0] addr_i,
  input  wire logic [15:0] dq_i,
  input  wire logic        chip_en_n_i,
  input  wire logic        write_en_n_i,
  input  wire logic        out_en_n_i,
  output logic      [15:0] dq_o
);
  logic [19:0] qa[$];
  logic [15:0] qd[$];
  logic [19:0] la = 20'h0_0000;
  logic [15:0] rv;
  logic [15:0] held = 16'h0000;
  logic        wa = 1'b0;
  logic        ident = 1'b0;
  // address latches at the later falling strobe
  always @(negedge write_en_n_i or negedge chip_en_n_i) begin
    if (!write_en_n_i && !chip_en_n_i) begin
      la = addr_i;
      wa = 1'b1;
    end
  end
  // data at the first rising strobe; only the low byte decodes commands
  always @(posedge write_en_n_i or posedge chip_en_n_i) begin
    if (wa) begin
      wa = 1'b0;
      if (dq_i[7:0] == 8'h90 && qd.size() > 0 && qd[$][7:0] == 8'h55) ident = 1'b1;
      else if (dq_i[7:0] == 8'hf0) ident = 1'b0;
      qa.push_back(la);
      qd.push_back(dq_i);
    end
  end
  // array data needs no command; identification overrides it
  always_comb begin
    rv = addr_i[15:0] ^ 16'hc3a5;
    if (ident) begin
      case (addr_i[7:0])
        8'h00: rv = MAKER;
        8'h01: rv = DEVICE;
        8'h02: rv = {15'h0000, addr_i[12]}; // protected when bit 12 set
        default: rv = 16'hffff;
      endcase
    end
  end
  // released bus shows the inverse, so a stale sample cannot pass
  assign dq_o = (!chip_en_n_i && !out_en_n_i) ? rv : ~held;
  always @(posedge out_en_n_i or posedge chip_en_n_i) held = rv;
endmodule // flash_dev_model
`default_nettype wire

// [dv/testbench.sv]
// self-checking bench for the flash command host against a flash model
// assumes the checker binds itself; default strobe timing, short window
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam logic [15:0] MK = 16'h00a5; // arbitrary value
  localparam logic [15:0] DV = 16'h5a3c; // arbitrary value
  logic        clk = 1'b0, rst_n = 1'b0, req = 1'b0, bm = 1'b0;
  logic [3:0]  op = 4'h0;
  logic [19:0] addr = 20'h0_0000, fa;
  logic [15:0] data = 16'h0000, rdata, hdq, mdq, bus;
  logic        busy, done, refd, byp, susp, win, doe, cen, wen, oen;
  int          mismatches = 0, checks = 0, cyc = 0;
  assign bus = doe ? hdq : mdq;
  flash_host #(.ERASE_WIN_CYC(50)) DUT (.clock_i(clk), .rst_n_i(rst_n), .ce_i(1'b1), .req_i(req),
    .op_i(op), .addr_i(addr), .data_i(data), .byte_mode_i(bm), .dq_i(bus), .busy_o(busy), .done_o(done),
    .refused_o(refd), .rdata_o(rdata), .bypass_o(byp), .suspended_o(susp), .window_o(win), .addr_o(fa),
    .dq_o(hdq), .dq_oe_o(doe), .chip_en_n_o(cen), .write_en_n_o(wen), .out_en_n_o(oen));
  flash_dev_model #(.MAKER(MK), .DEVICE(DV)) m (.addr_i(fa), .dq_i(bus), .chip_en_n_i(cen),
    .write_en_n_i(wen), .out_en_n_i(oen), .dq_o(mdq));
  initial forever #2 clk = ~clk;
  task automatic conclude;
    if (mismatches == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [19:0] s, input logic [19:0] e);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one request, then wait bounded for done or refusal
  task automatic run(input logic [3:0] o, input logic [19:0] a, input logic [15:0] d, input logic rf);
    int n = 0;
    @(negedge clk);
    m.qa.delete();
    m.qd.delete();
    op = o;
    addr = a;
    data = d;
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
    while (done !== 1'b1 && refd !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    chk("finished", 20'(n < 2000), 20'h0_0001);
    chk("refused", 20'(refd), 20'(rf));
  endtask
  task automatic cnt(input int n);
    chk("cycles", 20'(m.qa.size()), 20'(n));
  endtask
  task automatic ex(input int i, input logic [11:0] a, input logic [7:0] d);
    chk("cyc_addr", 20'(m.qa[i][11:0]), 20'(a));
    chk("cyc_data", 20'(m.qd[i][7:0]), 20'(d));
  endtask
  task automatic unl(input int i);
    ex(i, bm ? 12'haaa : 12'h555, 8'haa);
    ex(i + 1, bm ? 12'h555 : 12'h2aa, 8'h55);
  endtask
  task automatic t_read;
    run(4'h0, 20'h1_2345, 16'h0000, 1'b0);
    cnt(0);
    chk("rdata", 20'(rdata), 20'(16'h2345 ^ 16'hc3a5));
  endtask
  task automatic t_prog;
    run(4'h4, 20'ha_bcde, 16'h1234, 1'b0);
    cnt(4);
    unl(0);
    ex(2, bm ? 12'haaa : 12'h555, 8'ha0);
    chk("prog_addr", m.qa[3], 20'ha_bcde);
    chk("prog_data", 20'(m.qd[3] & (bm ? 16'h00ff : 16'hffff)), bm ? 20'h0_0034 : 20'h0_1234);
    run(4'h3, 20'h0_0000, 16'h0000, 1'b0);
    cnt(1);
    ex(0, bm ? 12'h0aa : 12'h055, 8'h98);
  endtask
  task automatic t_ident;
    run(4'h2, 20'h0_0001, 16'h0000, 1'b0);
    cnt(3);
    unl(0);
    ex(2, 12'h555, 8'h90);
    chk("dev_code", 20'(rdata), 20'(DV));
    run(4'h2, 20'h3_1002, 16'h0000, 1'b0);
    chk("protect", 20'(rdata), 20'h0_0001);
    run(4'h1, 20'h7_0123, 16'h0000, 1'b0);
    chk("reset_cmd", 20'(m.qd[0][7:0]), 20'h0_00f0);
    t_read();
  endtask
  task automatic t_bypass;
    run(4'h5, 20'h0_0000, 16'h0000, 1'b0);
    cnt(3);
    ex(2, 12'h555, 8'h20);
    chk("bypass_on", 20'(byp), 20'h0_0001);
    run(4'h6, 20'h5_4321, 16'hbeef, 1'b0);
    cnt(2);
    chk("byp_cmd", 20'(m.qd[0][7:0]), 20'h0_00a0);
    chk("byp_data", 20'(m.qd[1]), 20'h0_beef);
    chk("byp_addr", m.qa[1], 20'h5_4321);
    run(4'h4, 20'h5_4321, 16'hbeef, 1'b1);
    run(4'h7, 20'h0_0000, 16'h0000, 1'b0);
    cnt(2);
    chk("exit_data", {m.qd[0][7:0], m.qd[1][7:0]}, 20'h0_9000);
    chk("bypass_off", 20'(byp), 20'h0_0000);
  endtask
  task automatic t_erase;
    run(4'hb, 20'h0_0000, 16'h0000, 1'b1);
    run(4'h9, 20'ha_5000, 16'h0000, 1'b0);
    cnt(6);
    unl(0);
    ex(2, 12'h555, 8'h80);
    unl(3);
    chk("sector", {m.qa[5][19:12], m.qd[5][7:0]}, 20'h0_a530);
    chk("window", 20'(win), 20'h0_0001);
    run(4'ha, 20'hb_6000, 16'h0000, 1'b0);
    chk("add", {m.qa[0][19:12], m.qd[0][7:0]}, 20'h0_b630);
    repeat (60) @(negedge clk);
    chk("window_end", 20'(win), 20'h0_0000);
    run(4'ha, 20'hc_7000, 16'h0000, 1'b1);
    run(4'hc, 20'h0_0000, 16'h0000, 1'b1);
    run(4'hb, 20'h1_2345, 16'h0000, 1'b0);
    chk("suspend", {m.qd[0][7:0], 7'h00, susp}, 20'h0_b001);
    run(4'h4, 20'h0_0100, 16'h55aa, 1'b0);
    cnt(4);
    run(4'h2, 20'h0_0000, 16'h0000, 1'b0);
    chk("maker", 20'(rdata), 20'(MK));
    run(4'h1, 20'h0_0000, 16'h0000, 1'b0);
    run(4'hc, 20'h6_0000, 16'h0000, 1'b0);
    chk("resume", {m.qd[0][7:0], 7'h00, susp}, 20'h0_3000);
    run(4'hc, 20'h0_0000, 16'h0000, 1'b1);
    // second reset mid-run clears the erase state
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    run(4'h8, 20'h0_0000, 16'h0000, 1'b0);
    cnt(6);
    ex(5, 12'h555, 8'h10);
    run(4'hb, 20'h0_0000, 16'h0000, 1'b1);
  endtask
  // run length guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      mismatches++;
      conclude();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_read();
    for (int b = 0; b < 2; b++) begin
      bm = b[0];
      t_prog();
    end
    bm = 1'b0;
    t_ident();
    t_bypass();
    t_erase();
    conclude();
  end
endmodule // testbench
`default_nettype wire
